// [include/pml_pkg.sv]
// Package for the management, LED and power control block.
// Assumes a 100 MHz APB clock and an asynchronous active-low reset.
package pml_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_MHZ = 100;
	localparam int LED_PULSE_MS = 100;
	localparam int LED_PULSE_CYC = LED_PULSE_MS * 1000 * CLK_MHZ;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CFG18 = 8'h04;
	localparam logic [7:0] ADDR_EVENT = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_CABLE = 8'h10;
	localparam logic [7:0] ADDR_MDIO = 8'h14;

	// Field positions.
	localparam int CFG_IRQ_POL_BIT = 1;
	localparam int CFG_CABLE_DIS_BIT = 2;
	localparam int CTRL_IRQ_MODE_BIT = 0;
	localparam int CTRL_FIBER_BIT = 1;
	localparam int CTRL_LINK_BIT = 2;
	localparam int CTRL_SPEED10_BIT = 3;
	localparam int CTRL_FULL_DUP_BIT = 4;

	// Reset values.
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;
	localparam logic [31:0] CFG18_RST = 32'h0000_0000;
	localparam logic [2:0] CABLE_RST = 3'h0;

	typedef struct packed {
		logic speed;
		logic collision;
		logic link_act;
	} pml_led_t;

endpackage

// [rtl/pml_ctrl.sv]
// Management pin timing, interrupt, low-power and LED logic, with an APB register file.
// Assumes mdc, mdio, low_power_in_n, straps and activity pulses arrive asynchronously.
// Functional notes
// - Management data moves in both directions on the data pin synchronously to the management clock.
// - Incoming management data is sampled and outgoing data launched on the management clock rising edge.
// - The management clock may stop between transfers, so nothing depends on it running.
// - In interrupt mode the interrupt output is asserted while an event is pending, low by default, level set by bit 1 of reg 18.
// - With the low-power input low all blocks but energy detect and oscillator stop; high means normal.
// - With reset and low-power input both low, every block is disabled.
// - After link up the link/activity LED pulses active 100 ms per activity and stays inactive while link is down.
// - Each LED takes its polarity from its power-on strap: high strap active low, low strap active high.
// - The speed LED is 0 for 100 Mbit/s and 1 for 10 Mbit/s before strap inversion.
// - Without fiber mode and with bit 2 of reg 18 clear, the three LEDs show a cable-length code.
// - The collision LED is inactive in full duplex and pulses 100 ms per collision in half duplex.
`timescale 1ns/100ps
module pml_ctrl
	import pml_pkg::*;
#(
	parameter int PULSE_CYC = LED_PULSE_CYC
) (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Management link
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe_n,
	// Power, test and straps
	input wire logic low_power_in_n,
	input wire logic [1:0] test_in,
	input wire logic [2:0] led_strap_in,
	// Activity events from the datapath
	input wire logic activity_in,
	input wire logic collision_in,
	// Outputs
	output logic irq_out_n,
	output logic blocks_enable,
	output logic speed_led,
	output logic collision_led,
	output logic link_activity_led
);

	// ==========================================================
	// Parameter check
	// The timer needs at least one count below its load value to show a pulse at all.
	if (PULSE_CYC < 2) begin : g_pulse_cyc_check
		$error("PULSE_CYC too small");
	end

	// ==========================================================
	// Input synchronisers
	logic [1:0] mdc_s_ff, mdi_s_ff, lp_s_ff, act_s_ff, col_s_ff;
	logic [1:0] tst0_s_ff, tst1_s_ff;
	logic [2:0] strap_s0_ff, strap_s1_ff;
	logic mdc_d_ff, act_d_ff, col_d_ff;

	// Management link pins; the data pin idles high on its pull-up.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mdc_s_ff <= 2'h0;
			mdi_s_ff <= 2'h3;
		end else begin
			mdc_s_ff <= {mdc_s_ff[0], mdc};
			mdi_s_ff <= {mdi_s_ff[0], mdio_in};
		end
	end

	// Power and factory test pins, levels only.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lp_s_ff <= 2'h0;
			tst0_s_ff <= 2'h0;
			tst1_s_ff <= 2'h0;
		end else begin
			lp_s_ff <= {lp_s_ff[0], low_power_in_n};
			tst0_s_ff <= {tst0_s_ff[0], test_in[0]};
			tst1_s_ff <= {tst1_s_ff[0], test_in[1]};
		end
	end

	// LED strap pins; only the window before the capture below matters.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_s0_ff <= 3'h7;
			strap_s1_ff <= 3'h7;
		end else begin
			strap_s0_ff <= led_strap_in;
			strap_s1_ff <= strap_s0_ff;
		end
	end

	// Datapath event pins.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_s_ff <= 2'h0;
			col_s_ff <= 2'h0;
		end else begin
			act_s_ff <= {act_s_ff[0], activity_in};
			col_s_ff <= {col_s_ff[0], collision_in};
		end
	end

	// Edge history starts at each pin's idle level, so no false edge follows reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mdc_d_ff <= 1'b0;
			act_d_ff <= 1'b0;
			col_d_ff <= 1'b0;
		end else begin
			mdc_d_ff <= mdc_s_ff[1];
			act_d_ff <= act_s_ff[1];
			col_d_ff <= col_s_ff[1];
		end
	end

	// A stopped mdc just yields no edges; no watchdog relies on it running.
	logic mdc_rise;
	assign mdc_rise = mdc_s_ff[1] & ~mdc_d_ff;

	// ==========================================================
	// Strap capture, once after reset release
	logic strap_done_ff;
	logic [1:0] strap_wait_ff;
	logic [2:0] strap_ff;
	// The capture waits for the strap synchronisers to settle; later strap changes
	// are ignored, as a power-on setting should be.

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_wait_ff <= 2'h0;
			strap_done_ff <= 1'b0;
			strap_ff <= 3'h7;
		end else if (!strap_done_ff) begin
			strap_wait_ff <= strap_wait_ff + 2'h1;
			if (strap_wait_ff == 2'h3) begin
				strap_done_ff <= 1'b1;
				strap_ff <= strap_s1_ff;
			end
		end
	end

	// ==========================================================
	// Registers
	logic [31:0] ctrl_ff, cfg18_ff;
	logic [2:0] cable_ff;
	logic event_ff;
	logic [7:0] mdo_shift_ff, mdi_shift_ff;
	logic wr_en, rd_en;

	assign wr_en = psel & penable & pwrite;
	// Read data is registered in the setup cycle so that it stands through the access phase.
	assign rd_en = psel & ~penable & ~pwrite;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		return a == r;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return hit(a, ADDR_CTRL) | hit(a, ADDR_CFG18) | hit(a, ADDR_EVENT)
			| hit(a, ADDR_STATUS) | hit(a, ADDR_CABLE) | hit(a, ADDR_MDIO);
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= CTRL_RST;
			cfg18_ff <= CFG18_RST;
			cable_ff <= CABLE_RST;
		end else if (wr_en) begin
			if (hit(paddr, ADDR_CTRL)) begin
				ctrl_ff <= {27'h0, pwdata[4:0]};
			end
			if (hit(paddr, ADDR_CFG18)) begin
				cfg18_ff <= {29'h0, pwdata[2:1], 1'b0};
			end
			if (hit(paddr, ADDR_CABLE)) begin
				cable_ff <= pwdata[2:0];
			end
		end
	end

	// Pending event: hardware set wins over a software write-one clear.
	logic col_rise, act_rise;
	assign act_rise = act_s_ff[1] & ~act_d_ff;
	assign col_rise = col_s_ff[1] & ~col_d_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_ff <= 1'b0;
		end else if (col_rise) begin
			event_ff <= 1'b1;
		end else if (wr_en && hit(paddr, ADDR_EVENT) && pwdata[0]) begin
			event_ff <= 1'b0;
		end
	end

	// ==========================================================
	// Management pin shifters, both on mdc rising edges
	// A register write wins over a coinciding mdc edge; software loads between frames.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mdi_shift_ff <= 8'h00;
			mdo_shift_ff <= 8'hFF;
			mdio_out <= 1'b1;
			mdio_oe_n <= 1'b1;
		end else if (wr_en && hit(paddr, ADDR_MDIO)) begin
			mdo_shift_ff <= pwdata[7:0];
			mdio_oe_n <= ~pwdata[8];
		end else if (mdc_rise) begin
			mdi_shift_ff <= {mdi_shift_ff[6:0], mdi_s_ff[1]};
			mdio_out <= mdo_shift_ff[7];
			mdo_shift_ff <= {mdo_shift_ff[6:0], 1'b1};
		end
	end

	// ==========================================================
	// APB answer: one access phase, never a wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			// An unmapped offset is refused; the write path ignores it by itself.
			pslverr <= psel & ~penable & ~mapped(paddr);
		end
	end

	// APB read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else begin
			prdata <= 32'h0000_0000;
			if (rd_en) begin
				unique case (paddr)
					ADDR_CTRL: prdata <= ctrl_ff;
					ADDR_CFG18: prdata <= cfg18_ff;
					ADDR_EVENT: prdata <= {31'h0, event_ff};
					ADDR_STATUS: prdata <= {24'h0, strap_ff, tst1_s_ff[1], tst0_s_ff[1],
						lp_s_ff[1], 2'h0};
					ADDR_CABLE: prdata <= {29'h0, cable_ff};
					ADDR_MDIO: prdata <= {24'h0, mdi_shift_ff};
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ==========================================================
	// Power and interrupt
	logic run;
	// Reset low alone already clears everything; low power then keeps blocks off.
	assign run = lp_s_ff[1];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blocks_enable <= 1'b0;
		end else begin
			blocks_enable <= run;
		end
	end

	logic irq_active;
	assign irq_active = ctrl_ff[CTRL_IRQ_MODE_BIT] & event_ff;

	// Polarity bit 0 gives active low; bit 1 gives active high.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_out_n <= 1'b1;
		end else begin
			irq_out_n <= irq_active ^ ~cfg18_ff[CFG_IRQ_POL_BIT];
		end
	end

	// ==========================================================
	// LED pulse timers on the core clock
	localparam int CW = $clog2(PULSE_CYC + 1);
	logic [CW-1:0] act_cnt_ff, col_cnt_ff;
	logic link_up, full_dup;

	assign link_up = ctrl_ff[CTRL_LINK_BIT];
	assign full_dup = ctrl_ff[CTRL_FULL_DUP_BIT];

	function automatic logic [CW-1:0] pulse_next(input logic [CW-1:0] c, input logic ev);
		if (ev) begin
			return CW'(PULSE_CYC);
		end
		return (c == '0) ? c : c - CW'(1);
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_cnt_ff <= '0;
			col_cnt_ff <= '0;
		end else begin
			act_cnt_ff <= (link_up && run) ? pulse_next(act_cnt_ff, act_rise) : '0;
			col_cnt_ff <= (!full_dup && run) ? pulse_next(col_cnt_ff, col_rise) : '0;
		end
	end

	// ==========================================================
	// LED drive
	// The struct holds each LED as the level it shows with its strap high; a low
	// strap inverts it. Active flags are therefore held active low in the struct.
	pml_led_t lvl;
	logic cable_mode;
	assign cable_mode = ~ctrl_ff[CTRL_FIBER_BIT] & ~cfg18_ff[CFG_CABLE_DIS_BIT];

	function automatic logic led_pin(input logic strap_high_lvl, input logic strap);
		return strap_high_lvl ^ ~strap;
	endfunction

	always_comb begin
		if (cable_mode) begin
			// The cable code is given as the pins show it with every strap high.
			lvl.speed = cable_ff[2];
			lvl.collision = cable_ff[1];
			lvl.link_act = cable_ff[0];
		end else begin
			lvl.speed = ctrl_ff[CTRL_SPEED10_BIT];
			lvl.collision = (col_cnt_ff == '0);
			lvl.link_act = (act_cnt_ff == '0);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			speed_led <= 1'b1;
			collision_led <= 1'b1;
			link_activity_led <= 1'b1;
		end else begin
			speed_led <= led_pin(lvl.speed, strap_ff[2]);
			collision_led <= led_pin(lvl.collision, strap_ff[1]);
			link_activity_led <= led_pin(lvl.link_act, strap_ff[0]);
		end
	end

endmodule

// [testbench/pml_ctrl_props.sv]
// Port-level assertions for the management, LED and power control block.
// Assumes it is bound to pml_ctrl and that the interrupt mode bit stays set.
`timescale 1ns/100ps
module pml_ctrl_props
	import pml_pkg::*;
(
	// Clock, reset and APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// Link, power and outputs
	input wire logic mdc,
	input wire logic mdio_out,
	input wire logic low_power_in_n,
	input wire logic collision_in,
	input wire logic irq_out_n,
	input wire logic blocks_enable
);
	// ==========================================================
	// Shadow of the interrupt polarity bit, so the active level is known.
	logic pol_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) pol_ff <= 1'h0;
		else if (psel && penable && pready && pwrite && paddr == ADDR_CFG18) pol_ff <= pwdata[1];
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_apb_answer: assert property (psel && !penable |=> pready) else $error("no answer");
	a_ready_access: assert property (pready |-> psel && penable) else $error("stray ready");
	a_ready_once: assert property (pready |=> !pready) else $error("ready held");
	a_err_ready: assert property (pslverr |-> pready) else $error("stray error");
	a_mdio_launch: assert property ($changed(mdio_out) |-> $past(mdc))
		else $error("data launched off clock");
	a_low_off: assert property ($fell(low_power_in_n) |-> ##[1:5] !blocks_enable)
		else $error("blocks kept running");
	a_low_on: assert property ($rose(low_power_in_n) |-> ##[1:5] blocks_enable)
		else $error("blocks not restarted");
	a_irq_event: assert property ($rose(collision_in) |-> ##[3:8] irq_out_n == pol_ff)
		else $error("interrupt not raised");
endmodule

// [testbench/pml_mgmt_model.sv]
// Model of the management controller that clocks bytes over the serial link.
// Assumes the bench resolves the shared data wire, pulled up, into mdio_w.
`timescale 1ns/100ps
module pml_mgmt_model (
	// Clock and resolved wire
	input wire logic pclk,
	input wire logic mdio_w,
	// Towards the block
	output logic mdc,
	output logic drv,
	output logic drv_en
);
	// ==========================================================
	// Byte transfer, 80 ns per bit; the clock stands low between bytes.
	initial begin
		mdc = 1'h0;
		drv = 1'h1;
		drv_en = 1'h0;
	end

	task automatic xfer(input logic [7:0] tx, input logic drive, output logic [7:0] rx);
		logic [7:0] sh;
		sh = 8'h00;
		drv_en <= drive;
		for (int i = 7; i >= 0; i--) begin
			drv <= tx[i];
			repeat (4) @(posedge pclk);
			sh = {sh[6:0], mdio_w};
			mdc <= 1'h1;
			repeat (4) @(posedge pclk);
			mdc <= 1'h0;
		end
		repeat (4) @(posedge pclk);
		rx = {sh[6:0], mdio_w};
		drv_en <= 1'h0;
	endtask
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the management, LED and power control block.
// Assumes pml_pkg is compiled first; pulses are shortened to PW cycles.
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
module testbench
	import pml_pkg::*;
;
	// ==========================================================
	// Signals
	localparam int PW = 20;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0] paddr = 8'h00, rx;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [1:0] test_in = 2'h0;
	logic [2:0] led_strap_in = 3'h5;
	logic pready, pslverr, e, mdc, mdio_out, mdio_oe_n, drv, drv_en, mdio_w;
	logic low_power_in_n = 1'h0, activity_in = 1'h0, collision_in = 1'h0;
	logic irq_out_n, blocks_enable, speed_led, collision_led, link_activity_led;
	int error_cnt = 0, checked = 0, cyc = 0;

	always #5 pclk = ~pclk;
	assign mdio_w = !mdio_oe_n ? mdio_out : (drv_en ? drv : 1'h1);
	pml_ctrl #(.PULSE_CYC(PW)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mdc(mdc), .mdio_in(mdio_w), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
		.low_power_in_n(low_power_in_n), .test_in(test_in), .led_strap_in(led_strap_in),
		.activity_in(activity_in), .collision_in(collision_in), .irq_out_n(irq_out_n),
		.blocks_enable(blocks_enable), .speed_led(speed_led), .collision_led(collision_led),
		.link_activity_led(link_activity_led)
	);
	pml_mgmt_model mgmt (.pclk(pclk), .mdio_w(mdio_w), .mdc(mdc), .drv(drv), .drv_en(drv_en));

	// ==========================================================
	// Shared tasks
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task kick(input logic [1:0] ev);
		@(posedge pclk);
		{collision_in, activity_in} <= ev;
		repeat (4) @(posedge pclk);
		{collision_in, activity_in} <= 2'h0;
	endtask

	task end_sim;
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task t_regs;
		apb(1'h0, ADDR_CTRL, 32'h0);
		`CHK(q, CTRL_RST)
		apb(1'h0, 8'h18, 32'h0);
		`CHK(e, 1'h1)
		apb(1'h0, ADDR_STATUS, 32'h0);
		`CHK(q, 32'h0000_00A4)
		`CHK(irq_out_n, 1'h1)
		`CHK(blocks_enable, 1'h1)
		$display("t_regs done");
	endtask

	task t_mdio;
		apb(1'h1, ADDR_MDIO, 32'h0000_01A5);
		@(posedge pclk);
		`CHK(mdio_oe_n, 1'h0)
		mgmt.xfer(8'h00, 1'h0, rx);
		`CHK(rx, 8'hA5)
		apb(1'h1, ADDR_MDIO, 32'h0);
		repeat (50) @(posedge pclk);
		mgmt.xfer(8'h3C, 1'h1, rx);
		apb(1'h0, ADDR_MDIO, 32'h0);
		`CHK(q[7:0], 8'h3C)
		$display("t_mdio done");
	endtask

	task t_irq;
		kick(2'h2);
		repeat (8) @(posedge pclk);
		`CHK(irq_out_n, 1'h0)
		apb(1'h1, ADDR_CTRL, 32'h0000_0000);
		repeat (3) @(posedge pclk);
		`CHK(irq_out_n, 1'h1)
		apb(1'h1, ADDR_CTRL, 32'h0000_0001);
		apb(1'h1, ADDR_CFG18, 32'h0000_0002);
		repeat (3) @(posedge pclk);
		`CHK(irq_out_n, 1'h1)
		apb(1'h1, ADDR_EVENT, 32'h0000_0001);
		repeat (3) @(posedge pclk);
		`CHK(irq_out_n, 1'h0)
		apb(1'h1, ADDR_CFG18, 32'h0000_0004);
		repeat (3) @(posedge pclk);
		`CHK(irq_out_n, 1'h1)
		$display("t_irq done");
	endtask

	task t_power;
		@(posedge pclk);
		low_power_in_n <= 1'h0;
		repeat (6) @(posedge pclk);
		`CHK(blocks_enable, 1'h0)
		low_power_in_n <= 1'h1;
		repeat (6) @(posedge pclk);
		`CHK(blocks_enable, 1'h1)
		$display("t_power done");
	endtask

	// Straps are 101: speed and link LEDs active low, collision LED active high.
	task t_led;
		apb(1'h1, ADDR_CTRL, 32'h0000_0001);
		kick(2'h1);
		repeat (6) @(posedge pclk);
		`CHK(link_activity_led, 1'h1)
		`CHK(speed_led, 1'h0)
		apb(1'h1, ADDR_CTRL, 32'h0000_000D);
		kick(2'h1);
		repeat (4) @(posedge pclk);
		`CHK(link_activity_led, 1'h0)
		`CHK(speed_led, 1'h1)
		kick(2'h1);
		repeat (PW - 4) @(posedge pclk);
		`CHK(link_activity_led, 1'h0)
		repeat (12) @(posedge pclk);
		`CHK(link_activity_led, 1'h1)
		kick(2'h2);
		repeat (4) @(posedge pclk);
		`CHK(collision_led, 1'h1)
		apb(1'h1, ADDR_CTRL, 32'h0000_001D);
		repeat (PW) @(posedge pclk);
		kick(2'h2);
		repeat (4) @(posedge pclk);
		`CHK(collision_led, 1'h0)
		$display("t_led done");
	endtask

	task t_cable;
		apb(1'h1, ADDR_CABLE, 32'h0000_0001);
		apb(1'h1, ADDR_CFG18, 32'h0);
		repeat (3) @(posedge pclk);
		`CHK({speed_led, collision_led, link_activity_led}, 3'h3)
		apb(1'h1, ADDR_CTRL, 32'h0000_0003);
		repeat (3) @(posedge pclk);
		`CHK({speed_led, collision_led, link_activity_led}, 3'h1)
		$display("t_cable done");
	endtask

	// ==========================================================
	// Main sequence and hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			end_sim();
		end
	end

	initial begin
		repeat (9) @(posedge pclk);
		`CHK(blocks_enable, 1'h0)
		low_power_in_n <= 1'h1;
		@(posedge pclk);
		presetn <= 1'h1;
		repeat (10) @(posedge pclk);
		t_regs();
		t_mdio();
		t_irq();
		t_power();
		t_led();
		t_cable();
		end_sim();
	end
endmodule

bind pml_ctrl pml_ctrl_props u_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .mdc(mdc),
	.mdio_out(mdio_out), .low_power_in_n(low_power_in_n), .collision_in(collision_in),
	.irq_out_n(irq_out_n), .blocks_enable(blocks_enable)
);
